// [hw/kwr_regs.svh]
// register map, field positions, reset values and timing counts of the watchdog reset unit
`ifndef KWR_REGS_SVH
`define KWR_REGS_SVH

// register indices; byte address is four times the index
`define KWR_IDX_SEL        10'h0A9
`define KWR_IDX_KEY        10'h0AA

// selection register fields
`define KWR_FLD_FLAG       7
`define KWR_FLD_TAP        5
`define KWR_SEL_RST_COLD   8'h00
`define KWR_SEL_RST_WARM   8'h80

// key values
`define KWR_KEY_ARM        8'hA5
`define KWR_KEY_GO         8'h5A

// bus answers
`define KWR_RESP_OKAY      2'h0
`define KWR_RESP_SLVERR    2'h2

// timing: oscillator clock is CLK, 10 ns
`define KWR_CLKS_PER_STATE 2
`define KWR_STATES_PER_MC  6
`define KWR_MC_CLKS        (`KWR_CLKS_PER_STATE * `KWR_STATES_PER_MC)
`define KWR_HW_RST_MC      2
`define KWR_HW_RST_CLKS    (`KWR_HW_RST_MC * `KWR_MC_CLKS)
`define KWR_WD_DELAY_MC    2
`define KWR_SW_DELAY_MC    1
`define KWR_HOLD_MC        2
`define KWR_HOLD_CLKS      (`KWR_HOLD_MC * `KWR_MC_CLKS)
`define KWR_TICK_MC        2
`define KWR_TICK_CLKS      (`KWR_TICK_MC * `KWR_MC_CLKS)
`define KWR_WARN_CLKS      2
`define KWR_WD_BASE        22'h000040
`define KWR_TAP_BIT        12

`endif

// [hw/kwr_pkg.sv]
// types of the watchdog reset unit
package kwr_pkg;

    typedef enum logic [1:0] {RS_IDLE, RS_PEND, RS_HOLD} kwr_rs_t;

    typedef struct packed {
        logic [3:0]  phase;
        logic [4:0]  hw_cnt;
        logic        hw_act;
        logic        en;
        logic        stage2;
        logic [3:0]  code;
        logic        flag;
        logic        ram_keep;
        logic [4:0]  wd_pre;
        logic [21:0] wd_cnt;
        kwr_rs_t     rs;
        logic [4:0]  rs_cnt;
        logic        aw_v;
        logic [11:0] aw_a;
        logic        w_v;
        logic [7:0]  w_d;
        logic        w_s;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
    } kwr_state_t;

endpackage

// [hw/kwr_top.sv]
// keyed watchdog and reset control unit with an AXI4-Lite register port
//
// Overview of operation
// - a machine cycle is six states of two clocks, twelve clocks in all
// - reset pin high for two machine cycles starts a hardware reset
// - power-on reset loads every register default; RAM content undefined
// - hardware reset equals power-on reset but RAM is kept
// - hardware reset wins over a pending watchdog or software reset
// - every reset disables the watchdog; interval writable while disabled
// - once enabled, only a reset stops the watchdog or changes its interval
// - clear zeroes the count; counting goes on without pause
// - count reaching the interval overflows; chip reset two machine cycles later
// - watchdog reset drives reset pin high in state one phases a,b
// - watchdog and software resets keep RAM content
// - selection register resets to 00H cold, 80H after watchdog/software reset
// - selection register writes are ignored once the watchdog is enabled
// - interval code sets timeout 1536 clocks doubled per step
// - interval reads back last written, or the interval in force
// - bit 5 mirrors bit 12 of the internal counter, read only
// - reset-cause flag set by watchdog/software reset, cleared by cold reset
// - reserved bits 4 and 6 may read any value
// - key register is write only; reads have no side effect
// - sequencer starts in stage one; only A5H advances to stage two
// - stage two: A5H stays, 5AH enables/clears, other value soft-resets
// - sequencer stage is kept across unrelated accesses
// - wrong second key resets whether or not watchdog was enabled
// - software reset: one more machine cycle, then two-cycle reset
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "kwr_regs.svh"

module kwr_top
    import kwr_pkg::*;
(
    // clock and power-on reset
    input  wire logic        CLK,
    input  wire logic        RSTN,
    // reset pin, open drain style
    input  wire logic        RST_PIN_I,
    output logic             RST_PIN_O,
    output logic             RST_PIN_OE,
    // reset towards the rest of the chip
    output logic             CHIP_RST,
    output logic             RAM_KEEP,
    // axi4-lite write address
    input  wire logic [11:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    // axi4-lite write data
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // axi4-lite read address
    input  wire logic [11:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    // axi4-lite read data
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    kwr_state_t  q;
    kwr_state_t  d;
    logic [21:0] limit;
    logic        do_wr;
    logic [7:0]  sel_rd;
    logic        tick;

    // reset images of the selection register; a literal cannot be bit-selected
    localparam logic [7:0] sel_cold  = `KWR_SEL_RST_COLD;
    localparam logic [7:0] sel_warm  = `KWR_SEL_RST_WARM;
    localparam int         ovf_dly   = `KWR_WD_DELAY_MC * `KWR_MC_CLKS - 1;
    localparam int         hold_last = `KWR_HOLD_CLKS - 1;

    ////////////////////////////////////////////////////////////////////////
    // derived values

    assign limit = `KWR_WD_BASE << q.code;
    assign tick  = (q.wd_pre == 5'(`KWR_TICK_CLKS - 1));
    assign do_wr = q.aw_v && q.w_v && !q.bvalid;
    // reserved bits read zero, software may not count on it
    assign sel_rd = {q.flag, 1'b0, q.wd_cnt[`KWR_TAP_BIT], 1'b0, q.code};

    assign S_AXI_AWREADY = !q.aw_v;
    assign S_AXI_WREADY  = !q.w_v;
    assign S_AXI_ARREADY = !q.rvalid;
    assign S_AXI_BVALID  = q.bvalid;
    assign S_AXI_BRESP   = q.bresp;
    assign S_AXI_RVALID  = q.rvalid;
    assign S_AXI_RRESP   = q.rresp;
    assign S_AXI_RDATA   = {24'h000000, q.rdata};

    // warning pulse in the first two clocks of the hold
    assign RST_PIN_O  = 1'b1;
    assign RST_PIN_OE = (q.rs == RS_HOLD) && (q.rs_cnt < 5'(`KWR_WARN_CLKS));
    assign CHIP_RST   = q.hw_act || (q.rs == RS_HOLD);
    assign RAM_KEEP   = q.ram_keep;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;

        // machine cycle phase
        if (q.phase == 4'(`KWR_MC_CLKS - 1)) begin
            d.phase = 4'h0;
        end else begin
            d.phase = q.phase + 4'h1;
        end

        // bus channel capture
        if (S_AXI_AWVALID && !q.aw_v) begin
            d.aw_v = 1'b1;
            d.aw_a = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !q.w_v) begin
            d.w_v = 1'b1;
            d.w_d = S_AXI_WDATA[7:0];
            d.w_s = S_AXI_WSTRB[0];
        end
        if (q.bvalid && S_AXI_BREADY) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && S_AXI_RREADY) begin
            d.rvalid = 1'b0;
        end

        // reads never touch watchdog or sequencer state
        if (S_AXI_ARVALID && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp  = `KWR_RESP_OKAY;
            d.rdata  = 8'h00;
            if (S_AXI_ARADDR[11:2] == `KWR_IDX_SEL && S_AXI_ARADDR[1:0] == 2'h0) begin
                d.rdata = sel_rd;
            end else if (S_AXI_ARADDR[11:2] == `KWR_IDX_KEY
                         && S_AXI_ARADDR[1:0] == 2'h0) begin
                d.rdata = 8'h00;
            end else begin
                d.rresp = `KWR_RESP_SLVERR;
            end
        end

        // watchdog count, prescaled by two machine cycles
        if (q.en) begin
            d.wd_pre = tick ? 5'h00 : q.wd_pre + 5'h01;
            if (tick) begin
                d.wd_cnt = q.wd_cnt + 22'h000001;
            end
            if (q.wd_cnt == limit && q.rs == RS_IDLE) begin
                d.rs     = RS_PEND;
                d.rs_cnt = 5'(`KWR_WD_DELAY_MC * `KWR_MC_CLKS - 2);
            end
        end

        // register writes; both channels held until both present
        if (do_wr) begin
            d.aw_v   = 1'b0;
            d.w_v    = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `KWR_RESP_OKAY;
            if (q.aw_a[11:2] == `KWR_IDX_SEL && q.aw_a[1:0] == 2'h0) begin
                if (q.w_s && !q.en) begin
                    d.code = q.w_d[3:0];
                    // flag is stored but steers nothing
                    d.flag = q.w_d[`KWR_FLD_FLAG];
                end
            end else if (q.aw_a[11:2] == `KWR_IDX_KEY && q.aw_a[1:0] == 2'h0) begin
                if (q.w_s && q.rs == RS_IDLE) begin
                    if (!q.stage2) begin
                        // stage one ignores all but the arm key
                        d.stage2 = (q.w_d == `KWR_KEY_ARM);
                    end else if (q.w_d == `KWR_KEY_ARM) begin
                        d.stage2 = 1'b1;
                    end else if (q.w_d == `KWR_KEY_GO) begin
                        // enable, or clear without stopping the prescale
                        d.stage2 = 1'b0;
                        d.en     = 1'b1;
                        d.wd_cnt = 22'h000000;
                    end else begin
                        d.stage2 = 1'b0;
                        d.rs     = RS_PEND;
                        d.rs_cnt = 5'(`KWR_SW_DELAY_MC * `KWR_MC_CLKS - 2);
                    end
                end
            end else begin
                d.bresp = `KWR_RESP_SLVERR;
            end
        end

        // internal reset sequence
        unique case (q.rs)
            RS_IDLE: begin
            end
            RS_PEND: begin
                if (q.rs_cnt == 5'h00) begin
                    d.rs     = RS_HOLD;
                    d.phase  = 4'h0;
                end else begin
                    d.rs_cnt = q.rs_cnt - 5'h01;
                end
            end
            RS_HOLD: begin
                d.en       = 1'b0;
                d.stage2   = 1'b0;
                d.code     = sel_warm[3:0];
                d.flag     = sel_warm[`KWR_FLD_FLAG];
                d.wd_cnt   = 22'h000000;
                d.wd_pre   = 5'h00;
                d.ram_keep = 1'b1;
                if (q.rs_cnt == 5'(`KWR_HOLD_CLKS - 1)) begin
                    d.rs     = RS_IDLE;
                    d.rs_cnt = 5'h00;
                end else begin
                    d.rs_cnt = q.rs_cnt + 5'h01;
                end
            end
            default: begin
                d.rs = RS_IDLE;
            end
        endcase

        // hardware reset pin filter
        if (RST_PIN_I) begin
            if (q.hw_cnt == 5'(`KWR_HW_RST_CLKS - 1)) begin
                d.hw_act = 1'b1;
            end else begin
                d.hw_cnt = q.hw_cnt + 5'h01;
            end
        end else begin
            d.hw_cnt = 5'h00;
            d.hw_act = 1'b0;
        end

        // hardware reset overrides anything internal
        if (q.hw_act) begin
            d.en       = 1'b0;
            d.stage2   = 1'b0;
            d.code     = sel_cold[3:0];
            d.flag     = sel_cold[`KWR_FLD_FLAG];
            d.wd_cnt   = 22'h000000;
            d.wd_pre   = 5'h00;
            d.rs       = RS_IDLE;
            d.rs_cnt   = 5'h00;
            d.ram_keep = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            q          <= '0;
            q.code     <= sel_cold[3:0];
            q.flag     <= sel_cold[`KWR_FLD_FLAG];
            q.rs       <= RS_IDLE;
            q.ram_keep <= 1'b0;
            q.bresp    <= `KWR_RESP_OKAY;
            q.rresp    <= `KWR_RESP_OKAY;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    property p_phase_wrap;
        (q.phase == 4'(`KWR_MC_CLKS - 1) && q.rs != RS_PEND) |=> (q.phase == 4'h0);
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap");

    property p_hw_take;
        (RST_PIN_I && q.hw_cnt == 5'(`KWR_HW_RST_CLKS - 1)) |=> (CHIP_RST && q.hw_act);
    endproperty
    a_hw_take: assert property (p_hw_take) else $error("hardware reset not taken");

    property p_hw_wins;
        q.hw_act |=> (q.rs == RS_IDLE && !q.en && !q.flag);
    endproperty
    a_hw_wins: assert property (p_hw_wins) else $error("hardware reset lost");

    property p_hold_disables;
        (q.rs == RS_HOLD && !q.hw_act)
            |=> (!q.en && q.flag && q.code == sel_warm[3:0] && !q.stage2);
    endproperty
    a_hold_disables: assert property (p_hold_disables) else $error("warm reset state");

    property p_en_sticky;
        (q.en && !q.hw_act && q.rs != RS_HOLD) |=> (q.en && $stable(q.code));
    endproperty
    a_en_sticky: assert property (p_en_sticky) else $error("enabled watchdog changed");

    property p_overflow;
        (q.en && q.rs == RS_IDLE && q.wd_cnt == limit && !q.hw_act)
            |=> (q.rs == RS_PEND) ##ovf_dly (q.rs == RS_HOLD);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow reset timing");

    property p_warn;
        ($rose(q.rs == RS_HOLD) && !q.hw_act) |-> RST_PIN_OE ##1 RST_PIN_OE ##1 !RST_PIN_OE;
    endproperty
    a_warn: assert property (p_warn) else $error("warning pulse wrong");

    property p_hold_len;
        // own warning pulse lifts the pin, so judge the outside by the filter count
        ($rose(q.rs == RS_HOLD) && q.hw_cnt == 5'h00)
            |-> ##hold_last (q.rs == RS_HOLD || q.hw_act);
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold too short");

    property p_stage_one;
        (do_wr && q.aw_a == {`KWR_IDX_KEY, 2'h0} && q.w_s && !q.stage2
            && q.w_d != `KWR_KEY_ARM && q.rs == RS_IDLE && !q.hw_act) |=> !q.stage2;
    endproperty
    a_stage_one: assert property (p_stage_one) else $error("stage one advanced");

    property p_tap;
        q.rvalid && q.rresp == `KWR_RESP_OKAY && $past(S_AXI_ARADDR[11:2]) == `KWR_IDX_SEL
            && $past(S_AXI_ARVALID && !q.rvalid) |-> (q.rdata[`KWR_FLD_TAP]
            == $past(q.wd_cnt[`KWR_TAP_BIT]));
    endproperty
    a_tap: assert property (p_tap) else $error("tap mirror wrong");

    property p_go_key;
        (do_wr && q.aw_a == {`KWR_IDX_KEY, 2'h0} && q.w_s && q.stage2
            && q.w_d == `KWR_KEY_GO && q.rs == RS_IDLE && !q.hw_act)
            |=> (q.en && !q.stage2 && q.wd_cnt == 22'h000000);
    endproperty
    a_go_key: assert property (p_go_key) else $error("go key did not enable");

    property p_bad_key;
        (do_wr && q.aw_a == {`KWR_IDX_KEY, 2'h0} && q.w_s && q.stage2
            && q.w_d != `KWR_KEY_ARM && q.w_d != `KWR_KEY_GO
            && q.rs == RS_IDLE && !q.hw_act) |=> (q.rs == RS_PEND && !q.stage2);
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("wrong key did not reset");

    property p_sel_lock;
        (do_wr && q.aw_a == {`KWR_IDX_SEL, 2'h0} && q.en && q.rs != RS_HOLD && !q.hw_act)
            |=> ($stable(q.code) && $stable(q.flag));
    endproperty
    a_sel_lock: assert property (p_sel_lock) else $error("locked selection changed");

    property p_tick;
        (q.en && tick && q.rs != RS_HOLD && !q.hw_act && !do_wr)
            |=> (q.wd_cnt == $past(q.wd_cnt) + 22'h000001);
    endproperty
    a_tick: assert property (p_tick) else $error("counter did not advance");

    property p_prescale;
        (q.en && !tick && q.rs != RS_HOLD && !q.hw_act)
            |=> (q.wd_pre == $past(q.wd_pre) + 5'h01);
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler stalled");

    property p_read_quiet;
        (S_AXI_ARVALID && !q.rvalid && !do_wr && q.rs == RS_IDLE && !q.hw_act)
            |=> ($stable(q.stage2) && $stable(q.en));
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("read disturbed sequencer");

    property p_hw_ram;
        q.hw_act |=> (RAM_KEEP && q.code == sel_cold[3:0]);
    endproperty
    a_hw_ram: assert property (p_hw_ram) else $error("hardware reset state");

endmodule

// [tb/keyed_watchdog_reset_unit_tb.sv]
// self-checking bench of the keyed watchdog reset unit
`include "kwr_regs.svh"

module keyed_watchdog_reset_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] A_SEL = {`KWR_IDX_SEL, 2'b00};
    localparam logic [11:0] A_KEY = {`KWR_IDX_KEY, 2'b00};
    localparam logic [11:0] A_BAD = 12'h100;
    localparam int          TMO0  = 1536;

    logic        clk = 1'b0, rstn = 1'b0, pin_ext = 1'b0;
    logic        pin_i, pin_o, pin_oe, chip_rst, ram_keep;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    int          errors = 0, checks = 0, seed = 32'hC95A;

    // pin is high when either side pulls it up
    assign pin_i = pin_ext | (pin_oe & pin_o);
    always #5 clk = ~clk;

    kwr_top dut (.CLK(clk), .RSTN(rstn), .RST_PIN_I(pin_i), .RST_PIN_O(pin_o),
        .RST_PIN_OE(pin_oe), .CHIP_RST(chip_rst), .RAM_KEEP(ram_keep),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // timeout in clocks for an interval code: base doubles per step
    function automatic int tmo_clks(input logic [3:0] c);
        return TMO0 << c;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic hang(input string m);
        errors++;
        $display("[ERR] %0t wait ran out: %s", $time, m);
        tally_and_finish;
    endtask

    // bus tasks start right after an edge and end one edge after the answer
    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        int i;
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (i == 50) hang("write");
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (i == 50) hang("read");
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic waitr(input int lim, output int n);
        for (n = 0; n < lim && chip_rst !== 1'b1; n++) @(posedge clk);
        if (n == lim) hang("chip reset");
    endtask

    // counts reset cycles and warning cycles of one internal reset
    task automatic hold(output int h, output int o);
        h = 0;
        o = 0;
        while (chip_rst === 1'b1 && h < 100) begin
            o += int'(pin_oe === 1'b1);
            h++;
            @(posedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d, v;
        logic [1:0]  r;
        int          n, h, o, i, hi;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(A_SEL, d, r);
        chk(d, 32'h0, "sel after power-on");
        chk(ram_keep, 1'b0, "ram keep after power-on");
        chk(chip_rst, 1'b0, "no chip reset at start");
        $display("test reset done");
        for (i = 0; i < 6; i++) begin
            v = $random(seed);
            wr(A_SEL, v[7:0], r);
            rd(A_SEL, d, r);
            chk(d[3:0], v[3:0], "interval readback");
            chk(d[7], v[7], "flag readback");
            chk(d[31:8], 24'h0, "upper bits");
        end
        $display("test interval rw done");
        rd(A_BAD, d, r);
        chk(r, `KWR_RESP_SLVERR, "unmapped read");
        wr(A_BAD, 8'h12, r);
        chk(r, `KWR_RESP_SLVERR, "unmapped write");
        rd(A_KEY, d, r);
        chk(r, `KWR_RESP_OKAY, "key read");
        $display("test map done");
        // stage one keys other than the arm value leave the sequencer idle
        for (i = 0; i < 6; i++) begin
            v = $random(seed);
            if (v[7:0] == `KWR_KEY_ARM) v[0] = ~v[0];
            wr(A_KEY, v[7:0], r);
            wr(A_KEY, `KWR_KEY_GO, r);
        end
        wr(A_SEL, 8'h03, r);
        rd(A_SEL, d, r);
        chk(d[3:0], 4'h3, "still disabled after stray keys");
        $display("test stage one done");
        wr(A_SEL, 8'h00, r);
        wr(A_KEY, `KWR_KEY_ARM, r);
        rd(A_SEL, d, r);
        wr(A_KEY, `KWR_KEY_ARM, r);
        wr(A_KEY, `KWR_KEY_GO, r);
        wr(A_SEL, 8'h0F, r);
        rd(A_SEL, d, r);
        chk(d[3:0], 4'h0, "interval locked once enabled");
        // a missed clear would fire near 1550 cycles from here, about 750 after the clear
        repeat (800) @(posedge clk);
        wr(A_KEY, `KWR_KEY_ARM, r);
        wr(A_KEY, `KWR_KEY_GO, r);
        waitr(3000, n);
        hi = tmo_clks(4'h0);
        chk(n >= hi && n <= hi + 28, 1'b1, "timeout after clear");
        hold(h, o);
        chk(h, 24, "watchdog reset length");
        chk(o, 2, "warning pulse");
        rd(A_SEL, d, r);
        chk(d[7:0] & 8'h8F, `KWR_SEL_RST_WARM, "sel after watchdog reset");
        chk(ram_keep, 1'b1, "ram kept");
        wr(A_SEL, 8'h05, r);
        rd(A_SEL, d, r);
        chk(d[3:0], 4'h5, "disabled after watchdog reset");
        $display("test watchdog done");
        wr(A_KEY, `KWR_KEY_ARM, r);
        wr(A_KEY, 8'h11, r);
        waitr(100, n);
        chk(n >= 6 && n <= 14, 1'b1, "soft reset delay");
        hold(h, o);
        chk(h, 24, "soft reset length");
        rd(A_SEL, d, r);
        chk(d[7:0] & 8'h8F, `KWR_SEL_RST_WARM, "sel after soft reset");
        $display("test soft reset done");
        // second power-on: ram keep must drop so the pin test below can raise it
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk(ram_keep, 1'b0, "ram keep after second power-on");
        rd(A_SEL, d, r);
        chk(d[7:0] & 8'h8F, `KWR_SEL_RST_COLD, "sel after second power-on");
        $display("test second power-on done");
        hi = 0;
        pin_ext <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            hi += int'(chip_rst === 1'b1);
        end
        pin_ext <= 1'b0;
        chk(hi, 0, "short pin pulse ignored");
        repeat (4) @(posedge clk);
        pin_ext <= 1'b1;
        waitr(40, n);
        chk(n >= 22 && n <= 26, 1'b1, "pin reset delay");
        repeat (5) @(posedge clk);
        pin_ext <= 1'b0;
        repeat (4) @(posedge clk);
        rd(A_SEL, d, r);
        chk(d[7:0] & 8'h8F, `KWR_SEL_RST_COLD, "sel after pin reset");
        chk(ram_keep, 1'b1, "ram kept by pin reset");
        wr(A_KEY, `KWR_KEY_ARM, r);
        wr(A_KEY, 8'h33, r);
        // pin drops before the soft hold would end, so only priority keeps the flag clear
        pin_ext <= 1'b1;
        repeat (26) @(posedge clk);
        pin_ext <= 1'b0;
        repeat (40) @(posedge clk);
        rd(A_SEL, d, r);
        chk(d[7], 1'b0, "pin reset wins");
        $display("test pin reset done");
        tally_and_finish;
    end
endmodule
